//--- hdl/sil_latency_model.sv
// system instruction decode path and latency lookup with completion timer
// Functional notes
// (RULE1) each form gets one path and latency
// (RULE2) privilege adjust: microcoded, 13 reg, 18 mem
// (RULE3) page invalidate: fast path, 74/95 by mode
// (RULE4) timestamp reads: microcoded, 45+16 or 28+12
// (RULE5) model read: 68 int-ctrl, 38 segment bases
// (RULE6) model write: 119 int-ctrl, 59 segment bases
// (RULE7) other model registers: latency by register
// (RULE8) monitor/wait: fast path, only lower bound
// (RULE9) control writes: 60, 61, 55, bit-dependent
// (RULE10) segment limit load: microcoded, 14/16
// (RULE11) segment verify: microcoded, 8 reg, 10 mem
// (RULE12) count core cycles dispatch to visibility
`timescale 1ns/100ps
module sil_latency_model #(
	parameter int                 LAT_W     = sil_pkg::LAT_W,
	parameter logic [LAT_W-1:0]   WAIT_MIN  = 8'h01
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             dispatch,
	input  sil_pkg::sil_form_t    form,
	input  wire logic             mode64,
	input  wire logic             lateVariant,
	input  sil_pkg::sil_mreg_t    mregTarget,
	input  wire logic [LAT_W-1:0] mregOtherLat,
	input  wire logic [LAT_W-1:0] bitChangeAdj,
	output logic                  fastPath_reg,
	output logic                  microPath_reg,
	output logic [LAT_W-1:0]      latency_reg,
	output logic [LAT_W-1:0]      bridgeLat_reg,
	output logic                  lowerBound_reg,
	output logic                  variable_reg,
	output logic                  known_reg,
	output logic                  busy,
	output logic                  complete
);

	logic             fastPath_next;
	logic [LAT_W-1:0] latency_next;
	logic [LAT_W-1:0] bridgeLat_next;
	logic             lowerBound_next;
	logic             variable_next;
	logic             known_next;
	logic [LAT_W-1:0] mregRdLat;
	logic [LAT_W-1:0] mregWrLat;
	logic [LAT_W-1:0] timerCount;
	logic             segBase;

	// model register target decode; unlisted targets come from the caller's table
	assign segBase   = (mregTarget == sil_pkg::MREG_FIRST_SEG_BASE) ||
	                   (mregTarget == sil_pkg::MREG_SECOND_SEG_BASE);
	assign mregRdLat = (mregTarget == sil_pkg::MREG_INT_CTRL_BASE) ? sil_pkg::LAT_MRD_INT_CTRL : // [RULE5]
	                   segBase ? sil_pkg::LAT_MRD_SEG : mregOtherLat;                          // [RULE7]
	assign mregWrLat = (mregTarget == sil_pkg::MREG_INT_CTRL_BASE) ? sil_pkg::LAT_MWR_INT_CTRL : // [RULE6]
	                   segBase ? sil_pkg::LAT_MWR_SEG : mregOtherLat;                          // [RULE7]

	// one named term per table row, so each row can be traced alone
	logic             isAdjReg;
	logic             isAdjMem;
	logic             isInval;
	logic             isTsRead;
	logic             isTsReadId;
	logic             isMregRd;
	logic             isMregWr;
	logic             isMonArm;
	logic             isMonWait;
	logic             isCtrl0W32;
	logic             isCtrl0W64;
	logic             isCtrl4W;
	logic             isLimReg;
	logic             isLimMem;
	logic             isVerReg;
	logic             isVerMem;
	logic             isUnknown;

	// family terms; all but isMonitor share one latency selector
	logic             isAdj;
	logic             isTs;
	logic             isCtrlWr;
	logic             isLimit;
	logic             isVerify;
	logic             isMonitor;

	// per-family latency before the final selection
	logic [LAT_W-1:0] latAdj;
	logic [LAT_W-1:0] latInval;
	logic [LAT_W-1:0] latTs;
	logic [LAT_W-1:0] latCtrl;
	logic [LAT_W-1:0] latLimit;
	logic [LAT_W-1:0] latVerify;

	// form decode; an out-of-range code falls into none of the rows
	assign isAdjReg   = (form == sil_pkg::FORM_PRIV_ADJ_REG);
	assign isAdjMem   = (form == sil_pkg::FORM_PRIV_ADJ_MEM);
	assign isInval    = (form == sil_pkg::FORM_PAGE_INVAL);
	assign isTsRead   = (form == sil_pkg::FORM_TS_READ);
	assign isTsReadId = (form == sil_pkg::FORM_TS_READ_ID);
	assign isMregRd   = (form == sil_pkg::FORM_MREG_READ);
	assign isMregWr   = (form == sil_pkg::FORM_MREG_WRITE);
	assign isMonArm   = (form == sil_pkg::FORM_MONITOR_ARM);
	assign isMonWait  = (form == sil_pkg::FORM_MON_WAIT);
	assign isCtrl0W32 = (form == sil_pkg::FORM_CTRL0_WR32);
	assign isCtrl0W64 = (form == sil_pkg::FORM_CTRL0_WR64);
	assign isCtrl4W   = (form == sil_pkg::FORM_CTRL4_WR);
	assign isLimReg   = (form == sil_pkg::FORM_SEG_LIMIT_REG);
	assign isLimMem   = (form == sil_pkg::FORM_SEG_LIMIT_MEM);
	assign isVerReg   = (form == sil_pkg::FORM_SEG_VERIFY_REG);
	assign isVerMem   = (form == sil_pkg::FORM_SEG_VERIFY_MEM);
	assign isUnknown  = (form == sil_pkg::FORM_UNKNOWN);

	// families group the reg and mem flavours, the two timestamp reads, the three control writes and monitor/wait
	assign isAdj     = isAdjReg || isAdjMem;
	assign isTs      = isTsRead || isTsReadId;
	assign isCtrlWr  = isCtrl0W32 || isCtrl0W64 || isCtrl4W;
	assign isLimit   = isLimReg || isLimMem;
	assign isVerify  = isVerReg || isVerMem;
	assign isMonitor = isMonArm || isMonWait;

	// family latencies; control writes add the caller's bit-change cost
	assign latAdj    = isAdjMem ? sil_pkg::LAT_PRIV_ADJ_MEM : sil_pkg::LAT_PRIV_ADJ_REG;        // [RULE2]
	assign latInval  = mode64 ? sil_pkg::LAT_PAGE_INVAL_64 : sil_pkg::LAT_PAGE_INVAL_32;        // [RULE3]
	assign latTs     = lateVariant ? sil_pkg::LAT_TS_CORE_LATE : sil_pkg::LAT_TS_CORE;          // [RULE4]
	assign latCtrl   = (isCtrl4W ? sil_pkg::LAT_CTRL4_WR :
	                    isCtrl0W64 ? sil_pkg::LAT_CTRL0_WR64 : sil_pkg::LAT_CTRL0_WR32) + bitChangeAdj; // [RULE9]
	assign latLimit  = isLimMem ? sil_pkg::LAT_SEG_LIMIT_MEM : sil_pkg::LAT_SEG_LIMIT_REG;      // [RULE10]
	assign latVerify = isVerMem ? sil_pkg::LAT_SEG_VERIFY_MEM : sil_pkg::LAT_SEG_VERIFY_REG;    // [RULE11]

	// fast path rows; every other known form is microcoded
	assign fastPath_next = isInval ||    // [RULE3]
	                       isMonitor;    // [RULE8] [RULE1]

	// one latency per form; rows are disjoint so order carries no priority
	assign latency_next = isAdj     ? latAdj :
	                      isInval   ? latInval :
	                      isTs      ? latTs :
	                      isMregRd  ? mregRdLat :
	                      isMregWr  ? mregWrLat :
	                      isMonWait ? WAIT_MIN :       // [RULE8]
	                      isCtrlWr  ? latCtrl :
	                      isLimit   ? latLimit :
	                      isVerify  ? latVerify :
	                      sil_pkg::LAT_ZERO;           // [RULE1]

	// bridge clocks are a separate domain count, never added to core cycles
	assign bridgeLat_next = isTs ? (lateVariant ? sil_pkg::LAT_TS_BRIDGE_LATE : sil_pkg::LAT_TS_BRIDGE) : // [RULE4]
	                        sil_pkg::LAT_ZERO;

	// monitor arm has no figure at all; wait is a floor, not an exact value
	assign lowerBound_next = isMonitor;  // [RULE8]
	assign variable_next   = isCtrlWr;   // [RULE9]
	assign known_next      = !isUnknown;

	// only monitor/wait may run unbounded, so they do not arm the timer
	assign timerCount = lowerBound_next ? sil_pkg::LAT_ZERO : latency_next;

	// answer registers update on dispatch and hold until the next one
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fastPath_reg   <= sil_pkg::RST_FLAG;
			microPath_reg  <= sil_pkg::RST_FLAG;
			latency_reg    <= sil_pkg::RST_LAT;
			bridgeLat_reg  <= sil_pkg::RST_LAT;
			lowerBound_reg <= sil_pkg::RST_FLAG;
			variable_reg   <= sil_pkg::RST_FLAG;
			known_reg      <= sil_pkg::RST_FLAG;
		end else if (dispatch) begin
			fastPath_reg   <= fastPath_next;                // [RULE1]
			microPath_reg  <= known_next && !fastPath_next; // [RULE1]
			latency_reg    <= latency_next;
			bridgeLat_reg  <= bridgeLat_next;
			lowerBound_reg <= lowerBound_next;
			variable_reg   <= variable_next;
			known_reg      <= known_next;
		end
	end

	// completion timer counts core cycles from dispatch
	sil_lat_counter #(
		.W (LAT_W)
	) u_timer (
		.clk    (clk),
		.resetn (resetn),
		.load   (dispatch),   // [RULE12]
		.count  (timerCount),
		.busy   (busy),
		.done   (complete)
	);

endmodule

//--- hdl/sil_pkg.sv
// shared constants and types for the system instruction latency model
package sil_pkg;

	// instruction form codes presented on the query port
	typedef enum logic [4:0] {
		FORM_PRIV_ADJ_REG,
		FORM_PRIV_ADJ_MEM,
		FORM_PAGE_INVAL,
		FORM_TS_READ,
		FORM_TS_READ_ID,
		FORM_MREG_READ,
		FORM_MREG_WRITE,
		FORM_MONITOR_ARM,
		FORM_MON_WAIT,
		FORM_CTRL0_WR32,
		FORM_CTRL0_WR64,
		FORM_CTRL4_WR,
		FORM_SEG_LIMIT_REG,
		FORM_SEG_LIMIT_MEM,
		FORM_SEG_VERIFY_REG,
		FORM_SEG_VERIFY_MEM,
		FORM_UNKNOWN
	} sil_form_t;

	// model register targets
	typedef enum logic [1:0] {
		MREG_INT_CTRL_BASE,
		MREG_FIRST_SEG_BASE,
		MREG_SECOND_SEG_BASE,
		MREG_OTHER
	} sil_mreg_t;

	localparam int LAT_W = 8;

	localparam logic [LAT_W-1:0] LAT_PRIV_ADJ_REG    = 8'h0D; // 13
	localparam logic [LAT_W-1:0] LAT_PRIV_ADJ_MEM    = 8'h12; // 18
	localparam logic [LAT_W-1:0] LAT_PAGE_INVAL_64   = 8'h4A; // 74
	localparam logic [LAT_W-1:0] LAT_PAGE_INVAL_32   = 8'h5F; // 95
	localparam logic [LAT_W-1:0] LAT_TS_CORE         = 8'h2D; // 45
	localparam logic [LAT_W-1:0] LAT_TS_BRIDGE       = 8'h10; // 16
	localparam logic [LAT_W-1:0] LAT_TS_CORE_LATE    = 8'h1C; // 28
	localparam logic [LAT_W-1:0] LAT_TS_BRIDGE_LATE  = 8'h0C; // 12
	localparam logic [LAT_W-1:0] LAT_MRD_INT_CTRL    = 8'h44; // 68
	localparam logic [LAT_W-1:0] LAT_MRD_SEG         = 8'h26; // 38
	localparam logic [LAT_W-1:0] LAT_MWR_INT_CTRL    = 8'h77; // 119
	localparam logic [LAT_W-1:0] LAT_MWR_SEG         = 8'h3B; // 59
	localparam logic [LAT_W-1:0] LAT_CTRL0_WR32      = 8'h3C; // 60
	localparam logic [LAT_W-1:0] LAT_CTRL0_WR64      = 8'h3D; // 61
	localparam logic [LAT_W-1:0] LAT_CTRL4_WR        = 8'h37; // 55
	localparam logic [LAT_W-1:0] LAT_SEG_LIMIT_REG   = 8'h0E; // 14
	localparam logic [LAT_W-1:0] LAT_SEG_LIMIT_MEM   = 8'h10; // 16
	localparam logic [LAT_W-1:0] LAT_SEG_VERIFY_REG  = 8'h08; // 8
	localparam logic [LAT_W-1:0] LAT_SEG_VERIFY_MEM  = 8'h0A; // 10
	localparam logic [LAT_W-1:0] LAT_ZERO            = 8'h00;

	// reset values of the answer registers, then the counter's end values
	localparam logic [LAT_W-1:0] RST_LAT     = 8'h00;
	localparam logic             RST_FLAG    = 1'b0;
	localparam logic [LAT_W-1:0] CNT_DONE    = 8'h00;
	localparam logic [LAT_W-1:0] CNT_ONE     = 8'h01;

endpackage

//--- hdl/sil_lat_counter.sv
// down counter that marks when a dispatched instruction becomes visible
`timescale 1ns/100ps
module sil_lat_counter #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic         load,
	input  wire logic [W-1:0] count,
	output logic              busy,
	output logic              done
);

	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	logic         done_next;
	logic         busy_next;

	// a zero count never arms, so unbounded forms stay idle here
	assign cnt_next  = load ? count : (cnt_reg != '0 ? cnt_reg - 1'b1 : cnt_reg);
	assign done_next = !load && (cnt_reg == W'(1));
	assign busy_next = load ? (count != '0) : (cnt_reg > W'(1));

	// dispatch is cycle 0; done rises after count edges
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_reg <= '0;
			done    <= 1'b0;
			busy    <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			done    <= done_next;
			busy    <= busy_next;
		end
	end

endmodule

//--- test/sil_latency_monitor.sv
// concurrent checks on the latency model outputs
`timescale 1ns/100ps
module sil_latency_monitor (
	input	wire logic		clk, resetn, dispatch, mode64, lateVariant,
	input	sil_pkg::sil_form_t	form,
	input	sil_pkg::sil_mreg_t	mregTarget,
	input	wire logic [7:0]	latency_reg, bridgeLat_reg,
	input	wire logic		fastPath_reg, microPath_reg, lowerBound_reg, known_reg, busy, complete
);
	// one clock domain, so the defaults serve every property
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire logic takeF = dispatch && form == sil_pkg::FORM_PAGE_INVAL;
	a_one_path: assert property (known_reg |-> fastPath_reg != microPath_reg) else $error("path not unique");
	a_adjust_mem: assert property (dispatch && form == sil_pkg::FORM_PRIV_ADJ_MEM |=> microPath_reg && latency_reg == 8'h12)
		else $error("adjust latency wrong");
	a_inval_mode: assert property (takeF |=> fastPath_reg && latency_reg == ($past(mode64) ? 8'h4A : 8'h5F))
		else $error("invalidate latency wrong");
	a_bridge_count: assert property (dispatch && form == sil_pkg::FORM_TS_READ_ID |=> bridgeLat_reg == ($past(lateVariant) ? 8'h0C : 8'h10))
		else $error("bridge count wrong");
	a_mwr_ctrl: assert property (dispatch && form == sil_pkg::FORM_MREG_WRITE && mregTarget == sil_pkg::MREG_INT_CTRL_BASE |=> latency_reg == 8'h77)
		else $error("model write latency wrong");
	a_wait_floor: assert property (dispatch && form == sil_pkg::FORM_MON_WAIT |=> fastPath_reg && lowerBound_reg) else $error("wait not a floor");
	a_limit_reg: assert property (dispatch && form == sil_pkg::FORM_SEG_LIMIT_REG |=> microPath_reg && latency_reg == 8'h0E)
		else $error("limit latency wrong");
	a_done_time: assert property (dispatch && form == sil_pkg::FORM_SEG_VERIFY_REG ##1 !dispatch [*8] |=> complete)
		else $error("completion late");
	a_busy_done: assert property (complete |-> !busy) else $error("busy during completion");
	c_stamp: cover property (dispatch && form == sil_pkg::FORM_TS_READ);
	c_done: cover property (complete);
	c_back: cover property (dispatch ##1 dispatch);
endmodule
bind sil_latency_model sil_latency_monitor i_sil_latency_monitor (.clk(clk), .resetn(resetn), .dispatch(dispatch),
	.mode64(mode64), .lateVariant(lateVariant), .form(form), .mregTarget(mregTarget), .latency_reg(latency_reg),
	.bridgeLat_reg(bridgeLat_reg), .fastPath_reg(fastPath_reg), .microPath_reg(microPath_reg),
	.lowerBound_reg(lowerBound_reg), .known_reg(known_reg), .busy(busy), .complete(complete));

//--- test/testbench.sv
// directed bench for the latency model
`timescale 1ns/100ps
module testbench;
	logic			clk = 1'b0, resetn = 1'b0, dispatch = 1'b0, mode64 = 1'b0, lateVariant = 1'b0;
	sil_pkg::sil_form_t	form = sil_pkg::FORM_UNKNOWN;
	sil_pkg::sil_mreg_t	mregTarget = sil_pkg::MREG_OTHER;
	logic [7:0]		mregOtherLat = 8'h21, bitChangeAdj = 8'h00, latency_reg, bridgeLat_reg;
	logic			fastPath_reg, microPath_reg, lowerBound_reg, variable_reg, known_reg, busy, complete;
	int			errors = 0, num_checks = 0, n, c;
	sil_pkg::sil_form_t	fx[9] = '{sil_pkg::FORM_PRIV_ADJ_REG, sil_pkg::FORM_PRIV_ADJ_MEM, sil_pkg::FORM_CTRL0_WR32,
		sil_pkg::FORM_CTRL0_WR64, sil_pkg::FORM_CTRL4_WR, sil_pkg::FORM_SEG_LIMIT_REG, sil_pkg::FORM_SEG_LIMIT_MEM,
		sil_pkg::FORM_SEG_VERIFY_REG, sil_pkg::FORM_SEG_VERIFY_MEM};
	logic [7:0]		lx[9] = '{8'h0D, 8'h12, 8'h3C, 8'h3D, 8'h37, 8'h0E, 8'h10, 8'h08, 8'h0A};
	always #20 clk = ~clk;
	sil_latency_model i_sil_latency_model (.clk(clk), .resetn(resetn), .dispatch(dispatch), .form(form),
		.mode64(mode64), .lateVariant(lateVariant), .mregTarget(mregTarget), .mregOtherLat(mregOtherLat),
		.bitChangeAdj(bitChangeAdj), .fastPath_reg(fastPath_reg), .microPath_reg(microPath_reg),
		.latency_reg(latency_reg), .bridgeLat_reg(bridgeLat_reg), .lowerBound_reg(lowerBound_reg),
		.variable_reg(variable_reg), .known_reg(known_reg), .busy(busy), .complete(complete));
	task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// one dispatch pulse, answer read after the taking edge has landed
	task automatic go(sil_pkg::sil_form_t f, logic m, int t, logic [7:0] adj, logic [7:0] lat, logic fast);
		@(posedge clk);
		dispatch <= 1'b1;
		form <= f;
		mode64 <= m;
		lateVariant <= m;
		mregTarget <= sil_pkg::sil_mreg_t'(t);
		bitChangeAdj <= adj;
		@(posedge clk);
		dispatch <= 1'b0;
		#1;
		chk("latency", latency_reg, lat);
		chk("fast", fastPath_reg, fast);
		chk("micro", microPath_reg, f != sil_pkg::FORM_UNKNOWN && !fast);
	endtask
	// counts completion pulses; a stray one after an abort would show here
	task automatic pulses(int k);
		c = 0;
		repeat (k) begin
			@(posedge clk);
			#1 c += (complete === 1'b1);
		end
	endtask
	task automatic t_fixed;
		for (int i = 0; i < 9; i++) go(fx[i], 1'b0, 3, 8'h00, lx[i], 1'b0);
		go(sil_pkg::FORM_CTRL4_WR, 1'b0, 3, 8'h05, 8'h3C, 1'b0);
		chk("variable", variable_reg, 8'h01);
		$display("test fixed done");
	endtask
	task automatic t_modes;
		go(sil_pkg::FORM_PAGE_INVAL, 1'b1, 3, 8'h00, 8'h4A, 1'b1);
		go(sil_pkg::FORM_PAGE_INVAL, 1'b0, 3, 8'h00, 8'h5F, 1'b1);
		for (int i = 0; i < 4; i++) begin
			go(i[1] ? sil_pkg::FORM_TS_READ_ID : sil_pkg::FORM_TS_READ, i[0], 3, 8'h00, i[0] ? 8'h1C : 8'h2D, 1'b0);
			chk("bridge", bridgeLat_reg, i[0] ? 8'h0C : 8'h10);
		end
		$display("test modes done");
	endtask
	task automatic t_mreg;
		for (int t = 0; t < 4; t++) begin
			go(sil_pkg::FORM_MREG_READ, 1'b0, t, 8'h00, t == 0 ? 8'h44 : t == 3 ? 8'h21 : 8'h26, 1'b0);
			go(sil_pkg::FORM_MREG_WRITE, 1'b0, t, 8'h00, t == 0 ? 8'h77 : t == 3 ? 8'h21 : 8'h3B, 1'b0);
		end
		$display("test model registers done");
	endtask
	task automatic t_mon;
		go(sil_pkg::FORM_MONITOR_ARM, 1'b0, 3, 8'h00, 8'h00, 1'b1);
		chk("floor", lowerBound_reg, 8'h01);
		go(sil_pkg::FORM_MON_WAIT, 1'b0, 3, 8'h00, 8'h01, 1'b1);
		chk("floor", lowerBound_reg, 8'h01);
		pulses(20);
		chk("untimed", c[7:0], 8'h00);
		go(sil_pkg::FORM_UNKNOWN, 1'b0, 3, 8'h00, 8'h00, 1'b0);
		chk("known", known_reg, 8'h00);
		$display("test monitor done");
	endtask
	// two dispatches one idle cycle apart: the first count is aborted, only the second completes
	task automatic t_timer;
		go(sil_pkg::FORM_PRIV_ADJ_REG, 1'b0, 3, 8'h00, 8'h0D, 1'b0);
		go(sil_pkg::FORM_SEG_VERIFY_REG, 1'b0, 3, 8'h00, 8'h08, 1'b0);
		chk("busy", busy, 8'h01);
		n = 0;
		while (complete !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1 n++;
		end
		if (n == 20) begin
			errors++;
			tally_and_finish;
		end
		chk("timer", n[7:0], 8'h08);
		chk("idle", busy, 8'h00);
		pulses(20);
		chk("aborted", c[7:0], 8'h00);
		$display("test timer done");
	endtask
	// latency, known, busy and complete must read zero as reset is let go
	task automatic t_reset;
		#1;
		chk("rst latency", latency_reg, 8'h00);
		chk("rst known", known_reg, 8'h00);
		chk("rst busy", busy, 8'h00);
		chk("rst complete", complete, 8'h00);
		$display("test reset done");
	endtask
	initial begin
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		t_reset;
		t_fixed;
		t_modes;
		t_mreg;
		t_mon;
		t_timer;
		tally_and_finish;
	end
endmodule
